// ==== logic/art_pkg.sv ====
/*
 * Constants for the auto-reload PWM timer: register map, field positions,
 * reset values and sizes.
 * Assumes a 32-bit Avalon-MM register bus with byte addresses, one word each.
 */
package art_pkg;

    // ==========================================================
    // register byte offsets
    localparam logic [5:0] ART_OFS_CTRL_STATUS = 6'h00;
    localparam logic [5:0] ART_OFS_COUNTER = 6'h04;
    localparam logic [5:0] ART_OFS_RELOAD = 6'h08;
    localparam logic [5:0] ART_OFS_PWM_CTRL = 6'h0C;
    localparam logic [5:0] ART_OFS_DUTY0 = 6'h10;
    // irq words sit above the four duty words so no channel aliases them
    localparam logic [5:0] ART_OFS_IRQ_STATUS = 6'h20;
    localparam logic [5:0] ART_OFS_IRQ_MASK = 6'h24;
    localparam int ART_ADDR_W = 6;

    // ==========================================================
    // timer_control_status fields
    localparam int ART_BIT_CLK_SRC = 7;
    localparam int ART_CC_LSB = 4;
    localparam int ART_BIT_RUN = 3;
    localparam int ART_BIT_FORCE = 2;
    localparam int ART_BIT_OIE = 1;
    localparam int ART_BIT_OVF = 0;

    // pwm_output_control fields
    localparam int ART_OE_LSB = 4;
    localparam int ART_OP_LSB = 0;

    // irq status/mask bit
    localparam int ART_IRQ_OVF = 0;

    // ==========================================================
    // sizes and reset values
    localparam int ART_CHANNELS = 4;
    localparam int ART_PRESC_W = 7;
    localparam logic [7:0] ART_RST_BYTE = 8'h00;
    localparam logic [6:0] ART_RST_PRESC = 7'h00;
    localparam logic [7:0] ART_CNT_MAX = 8'hFF;

endpackage

// ==== logic/art_pwm_timer.sv ====
/*
 * 8-bit auto-reload timer with four PWM channels, Avalon-MM register slave
 * and one level interrupt.
 * Assumes the external clock input is already synchronous to clk_sys; it is
 * counted on its rising edges, so it must be slower than half of clk_sys.
 */
`timescale 1ns/1ps

// Functional notes
// [R1] clock source bit picks cpu or external
// [R2] divider field selects prescaler tap 2^n
// [R3] run bit zero freezes prescaler and counter
// [R4] force reload bit always reads zero
// [R5] force reload loads reload value, clears prescaler
// [R6] overflow enable gates flag onto interrupt
// [R7] flag set on overflow, cleared by read
// [R8] counter register reads live, write replaces
// [R9] overflow reloads counter from reload value
// [R10] overflow drives outputs to polarity level; code does so only where the reload value is at or below the compare shadow
// [R11] output enable connects channel to pin
// [R12] output high at or below compare
// [R13] polarity change inverts output at once
// [R14] per-channel duty register sets second edge
// [R15] control/status resets to all zeros
// [R16] compare shadow loaded from duty on overflow
// [R17] counter steps once per prescaler edge
// [R18] counter write also clears prescaler
module art_pwm_timer
#(
    parameter int CHANNELS = art_pkg::ART_CHANNELS
)
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // avalon-mm slave
    input wire logic [art_pkg::ART_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // timer pins
    input wire logic ext_clk,
    output logic [CHANNELS-1:0] pwm_pin,
    output logic [CHANNELS-1:0] pwm_pin_oe,
    output logic irq
);
    import art_pkg::*;

    // ==========================================================
    // register state
    logic clock_source_select_reg;
    logic [2:0] clock_divider_select_reg;
    logic counter_run_enable_reg;
    logic overflow_irq_enable_reg;
    logic overflow_flag_reg;
    logic [7:0] reload_value_reg;
    logic [7:0] pwm_output_control_reg;
    logic [7:0] channel_duty_cycle_reg [CHANNELS];
    logic [7:0] channel_compare_shadow_reg [CHANNELS];
    logic [7:0] counter_reg;
    logic [ART_PRESC_W-1:0] prescaler_reg;
    logic ext_clk_reg;
    logic irq_status_reg;
    logic irq_mask_reg;
    logic [31:0] avs_readdata_reg;
    logic ack_reg;

    // ==========================================================
    // bus decode
    // one wait state: waitrequest drops in the cycle after the request is seen
    logic bus_req;
    logic wr_en;
    logic rd_en;
    assign bus_req = avs_read | avs_write;
    assign avs_waitrequest = bus_req & ~ack_reg;
    assign wr_en = avs_write & ack_reg & avs_byteenable[0];
    // read side effects fire on the capture edge, so an overflow landing
    // after the data was taken is never cleared unseen
    assign rd_en = avs_read & ~ack_reg;
    assign avs_readdata = avs_readdata_reg;

    function automatic logic hit(input logic [ART_ADDR_W-1:0] a,
                                 input logic [ART_ADDR_W-1:0] ofs);
        hit = (a == ofs);
    endfunction

    function automatic logic duty_hit(input logic [ART_ADDR_W-1:0] a, input int ch);
        duty_hit = (a == ART_OFS_DUTY0 + ART_ADDR_W'(ch * 4));
    endfunction

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            ack_reg <= 1'b0;
        end
        else
        begin
            ack_reg <= bus_req & ~ack_reg;
        end
    end

    // ==========================================================
    // counter clock generation
    // input select then a 7-bit prescaler; the carry into the tap
    // on the next step is the counter's enable pulse, whichever way the tap bit moves
    logic ext_rise;
    logic input_tick;
    logic [ART_PRESC_W-1:0] presc_next;
    logic count_tick;
    logic force_write;
    logic counter_write;
    logic overflow;

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            ext_clk_reg <= 1'b0;
        end
        else
        begin
            ext_clk_reg <= ext_clk;
        end
    end

    assign ext_rise = ext_clk & ~ext_clk_reg;
    assign input_tick = clock_source_select_reg ? ext_rise : 1'b1; // [R1]
    assign presc_next = prescaler_reg + ART_PRESC_W'(1);

    // tick when all bits below the selected tap carry over
    always_comb
    begin
        count_tick = 1'b0;
        if (counter_run_enable_reg && input_tick) // [R3]
        begin
            if (clock_divider_select_reg == 3'd0)
            begin
                count_tick = 1'b1;
            end
            else
            begin
                count_tick = (prescaler_reg & ((ART_PRESC_W'(1) << clock_divider_select_reg)
                              - ART_PRESC_W'(1))) == ((ART_PRESC_W'(1)
                              << clock_divider_select_reg) - ART_PRESC_W'(1)); // [R2]
            end
        end
    end

    assign force_write = wr_en && hit(avs_address, ART_OFS_CTRL_STATUS)
                         && avs_writedata[ART_BIT_FORCE];
    assign counter_write = wr_en && hit(avs_address, ART_OFS_COUNTER);
    assign overflow = count_tick && (counter_reg == ART_CNT_MAX);

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            prescaler_reg <= ART_RST_PRESC;
        end
        else if (force_write || counter_write) // [R5] [R18]
        begin
            prescaler_reg <= ART_RST_PRESC;
        end
        else if (counter_run_enable_reg && input_tick) // [R3]
        begin
            prescaler_reg <= presc_next;
        end
    end

    // ==========================================================
    // counter
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            counter_reg <= ART_RST_BYTE;
        end
        else if (counter_write) // [R8]
        begin
            counter_reg <= avs_writedata[7:0];
        end
        else if (force_write) // [R5]
        begin
            counter_reg <= reload_value_reg;
        end
        else if (overflow) // [R9]
        begin
            counter_reg <= reload_value_reg;
        end
        else if (count_tick) // [R17]
        begin
            counter_reg <= counter_reg + 8'h01;
        end
    end

    // ==========================================================
    // control and data registers
    always_ff @(posedge clk_sys)
    begin
        if (reset) // [R15]
        begin
            clock_source_select_reg <= 1'b0;
            clock_divider_select_reg <= 3'd0;
            counter_run_enable_reg <= 1'b0;
            overflow_irq_enable_reg <= 1'b0;
        end
        else if (wr_en && hit(avs_address, ART_OFS_CTRL_STATUS))
        begin
            clock_source_select_reg <= avs_writedata[ART_BIT_CLK_SRC];
            clock_divider_select_reg <= avs_writedata[ART_CC_LSB +: 3];
            counter_run_enable_reg <= avs_writedata[ART_BIT_RUN];
            overflow_irq_enable_reg <= avs_writedata[ART_BIT_OIE];
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            reload_value_reg <= ART_RST_BYTE;
            pwm_output_control_reg <= ART_RST_BYTE;
        end
        else if (wr_en)
        begin
            if (hit(avs_address, ART_OFS_RELOAD))
            begin
                reload_value_reg <= avs_writedata[7:0];
            end
            if (hit(avs_address, ART_OFS_PWM_CTRL))
            begin
                pwm_output_control_reg <= avs_writedata[7:0];
            end
        end
    end

    // ==========================================================
    // overflow flag and interrupt
    // set wins over the clearing read in the same cycle
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            overflow_flag_reg <= 1'b0;
        end
        else if (overflow) // [R7]
        begin
            overflow_flag_reg <= 1'b1;
        end
        else if (rd_en && hit(avs_address, ART_OFS_CTRL_STATUS)) // [R7]
        begin
            overflow_flag_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            irq_status_reg <= 1'b0;
            irq_mask_reg <= 1'b0;
        end
        else
        begin
            if (overflow)
            begin
                irq_status_reg <= 1'b1;
            end
            else if (wr_en && hit(avs_address, ART_OFS_IRQ_STATUS)
                     && avs_writedata[ART_IRQ_OVF])
            begin
                irq_status_reg <= 1'b0;
            end
            if (wr_en && hit(avs_address, ART_OFS_IRQ_MASK))
            begin
                irq_mask_reg <= avs_writedata[ART_IRQ_OVF];
            end
        end
    end

    // either path raises the line: legacy enable on the flag, or mask on status
    assign irq = (overflow_irq_enable_reg & overflow_flag_reg) // [R6]
                 | (irq_mask_reg & irq_status_reg);

    // ==========================================================
    // pwm channels
    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch++)
        begin : g_chan
            always_ff @(posedge clk_sys)
            begin
                if (reset)
                begin
                    channel_duty_cycle_reg[ch] <= ART_RST_BYTE;
                    channel_compare_shadow_reg[ch] <= ART_RST_BYTE;
                end
                else
                begin
                    if (wr_en && duty_hit(avs_address, ch)) // [R14]
                    begin
                        channel_duty_cycle_reg[ch] <= avs_writedata[7:0];
                    end
                    if (overflow) // [R16]
                    begin
                        channel_compare_shadow_reg[ch] <= channel_duty_cycle_reg[ch];
                    end
                end
            end

            // on overflow the counter becomes the reload value; where that is at or
            // below the compare, the level goes to the polarity-selected one
            logic below;
            assign below = counter_reg <= channel_compare_shadow_reg[ch]; // [R12] [R10]
            // polarity applied combinationally so a change shows at once
            assign pwm_pin[ch] = pwm_output_control_reg[ART_OE_LSB + ch]
                                 & (below ^ pwm_output_control_reg[ART_OP_LSB + ch]); // [R13]
            assign pwm_pin_oe[ch] = pwm_output_control_reg[ART_OE_LSB + ch]; // [R11]
        end
    endgenerate

    // ==========================================================
    // read data
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            avs_readdata_reg <= 32'h0000_0000;
        end
        else if (avs_read && !ack_reg)
        begin
            avs_readdata_reg <= 32'h0000_0000;
            case (avs_address)
                ART_OFS_CTRL_STATUS:
                    avs_readdata_reg[7:0] <= {clock_source_select_reg,
                        clock_divider_select_reg, counter_run_enable_reg,
                        1'b0, overflow_irq_enable_reg, overflow_flag_reg}; // [R4]
                ART_OFS_COUNTER: avs_readdata_reg[7:0] <= counter_reg; // [R8]
                ART_OFS_RELOAD: avs_readdata_reg[7:0] <= reload_value_reg;
                ART_OFS_PWM_CTRL: avs_readdata_reg[7:0] <= pwm_output_control_reg;
                ART_OFS_IRQ_STATUS: avs_readdata_reg[0] <= irq_status_reg;
                ART_OFS_IRQ_MASK: avs_readdata_reg[0] <= irq_mask_reg;
                default:
                begin
                    for (int i = 0; i < CHANNELS; i++)
                    begin
                        if (duty_hit(avs_address, i))
                        begin
                            avs_readdata_reg[7:0] <= channel_duty_cycle_reg[i];
                        end
                    end
                end
            endcase
        end
    end

endmodule

// ==== tb/art_pwm_timer_asserts.sv ====
/*
 * Concurrent checks on the ports of the auto-reload PWM timer, bound to every instance.
 * Assumes the one-wait-state Avalon-MM slave and registered read data of the design.
 */
`timescale 1ns/1ps

module art_pwm_timer_asserts
    import art_pkg::*;
#(
    parameter int CHANNELS = art_pkg::ART_CHANNELS
)
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // avalon-mm slave
    input wire logic [art_pkg::ART_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    // timer pins
    input wire logic ext_clk,
    input wire logic [CHANNELS-1:0] pwm_pin,
    input wire logic [CHANNELS-1:0] pwm_pin_oe,
    input wire logic irq
);
    default clocking cb @(posedge clk_sys);
    endclocking

    // ==========================================================
    // shadows of what software wrote, taken from the bus alone
    logic wr_commit;
    logic [7:0] ctl_seen;
    logic [7:0] pwm_seen;
    logic mask_seen;
    assign wr_commit = avs_write && !avs_waitrequest && avs_byteenable[0];

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            ctl_seen <= 8'h00;
            pwm_seen <= 8'h00;
            mask_seen <= 1'b0;
        end
        else if (wr_commit)
        begin
            if (avs_address == ART_OFS_CTRL_STATUS)
                ctl_seen <= avs_writedata[7:0];
            if (avs_address == ART_OFS_PWM_CTRL)
                pwm_seen <= avs_writedata[7:0];
            if (avs_address == ART_OFS_IRQ_MASK)
                mask_seen <= avs_writedata[ART_IRQ_OVF];
        end
    end

    // ==========================================================
    // properties
    sequence s_req_start;
        $rose(avs_read || avs_write);
    endsequence
    sequence s_one_wait;
        avs_waitrequest ##1 !avs_waitrequest;
    endsequence
    // ext input quiet for three cycles so no overflow can race the clear
    sequence s_flag_read;
        avs_read && !avs_waitrequest && avs_address == ART_OFS_CTRL_STATUS
            && avs_readdata[1:0] == 2'b11 && !mask_seen && ctl_seen[ART_BIT_CLK_SRC]
            && !ext_clk && !$past(ext_clk) && !$past(ext_clk, 2);
    endsequence

    property p_wait_state;
        disable iff (reset) s_req_start |-> s_one_wait;
    endproperty
    property p_upper_zero;
        disable iff (reset) avs_read && !avs_waitrequest |-> avs_readdata[31:8] == '0;
    endproperty
    property p_force_reads_zero;
        disable iff (reset) avs_read && !avs_waitrequest && avs_address == ART_OFS_CTRL_STATUS
            |-> !avs_readdata[ART_BIT_FORCE];
    endproperty
    property p_pin_off;
        disable iff (reset) (pwm_pin & ~pwm_pin_oe) == '0;
    endproperty
    property p_oe_from_write;
        disable iff (reset) $changed(pwm_pin_oe)
            |-> $past(avs_write && !avs_waitrequest && avs_address == ART_OFS_PWM_CTRL);
    endproperty
    property p_pol_flip;
        disable iff (reset) wr_commit && avs_address == ART_OFS_PWM_CTRL
            && !ctl_seen[ART_BIT_RUN] && pwm_seen[ART_OE_LSB] && avs_writedata[ART_OE_LSB]
            && avs_writedata[0] != pwm_seen[0] |=> pwm_pin[0] != $past(pwm_pin[0]);
    endproperty
    property p_no_irq_masked;
        disable iff (reset) !ctl_seen[ART_BIT_OIE] && !mask_seen |-> !irq;
    endproperty
    property p_flag_read_clear;
        disable iff (reset) s_flag_read |=> !irq;
    endproperty
    property p_reset_clear;
        reset |=> !irq && pwm_pin == '0 && pwm_pin_oe == '0;
    endproperty

    a_wait_state: assert property (p_wait_state)
        else $error("wait state not exactly one");
    a_upper_zero: assert property (p_upper_zero)
        else $error("read data upper bits set");
    a_force_reads_zero: assert property (p_force_reads_zero)
        else $error("force bit read as one");
    a_pin_off: assert property (p_pin_off)
        else $error("disabled channel drives high");
    a_oe_from_write: assert property (p_oe_from_write)
        else $error("enable moved without write");
    a_pol_flip: assert property (p_pol_flip)
        else $error("polarity write did not invert");
    a_no_irq_masked: assert property (p_no_irq_masked)
        else $error("interrupt while disabled");
    a_flag_read_clear: assert property (p_flag_read_clear)
        else $error("flag survived read");
    a_reset_clear: assert property (p_reset_clear)
        else $error("outputs not cleared by reset");
endmodule

bind art_pwm_timer art_pwm_timer_asserts #(.CHANNELS(CHANNELS)) u_asserts (
    .clk_sys(clk_sys), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .ext_clk(ext_clk),
    .pwm_pin(pwm_pin), .pwm_pin_oe(pwm_pin_oe), .irq(irq));

// ==== tb/test_art_pwm_timer.sv ====
/*
 * Self-checking bench for the auto-reload PWM timer over its Avalon-MM port.
 * Assumes the checker is bound separately; ext_clk is driven slowly and synchronously.
 */
`timescale 1ns/1ps

module test_art_pwm_timer;
    import art_pkg::*;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic [ART_ADDR_W-1:0] avs_address = '0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [3:0] avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic ext_clk = 1'b0;
    logic [3:0] pwm_pin;
    logic [3:0] pwm_pin_oe;
    logic irq;
    int fail_count = 0;
    int checks_done = 0;

    always #25 clk_sys = ~clk_sys;

    art_pwm_timer #(.CHANNELS(4)) u_dut (
        .clk_sys(clk_sys), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .ext_clk(ext_clk),
        .pwm_pin(pwm_pin), .pwm_pin_oe(pwm_pin_oe), .irq(irq));

    // ==========================================================
    // shared tasks
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // entered just after a rising edge; one idle edge follows so calls never collide
    task automatic bus(input logic we, input logic [ART_ADDR_W-1:0] a, input logic [7:0] d,
                       input logic [3:0] be, output logic [31:0] rd);
        int n;
        rd = 32'h0000_0000;
        avs_address <= a;
        avs_writedata <= {24'h00_0000, d};
        avs_byteenable <= be;
        avs_write <= we;
        avs_read <= !we;
        for (n = 0; n < 20; n++)
        begin
            @(posedge clk_sys);
            if (avs_waitrequest === 1'b0)
                break;
        end
        rd = avs_readdata;
        if (n == 20)
        begin
            fail_count++;
            final_report();
        end
        else
        begin
            avs_write <= 1'b0;
            avs_read <= 1'b0;
            @(posedge clk_sys);
        end
    endtask

    task automatic wr(input logic [ART_ADDR_W-1:0] a, input logic [7:0] d);
        logic [31:0] rd;
        bus(1'b1, a, d, 4'hF, rd);
    endtask

    task automatic rd_chk(input string what, input logic [ART_ADDR_W-1:0] a, input logic [7:0] e);
        logic [31:0] rd;
        bus(1'b0, a, 8'h00, 4'hF, rd);
        check(what, rd, {24'h00_0000, e});
    endtask

    // each rising edge of the external input is one prescaler tick
    task automatic pulse(input int k);
        repeat (k)
        begin
            ext_clk <= 1'b1;
            repeat (3) @(posedge clk_sys);
            ext_clk <= 1'b0;
            repeat (3) @(posedge clk_sys);
        end
    endtask

    // ==========================================================
    // scenarios
    task automatic t_reset();
        logic [31:0] rd;
        rd_chk("ctrl", ART_OFS_CTRL_STATUS, 8'h00);
        rd_chk("counter", ART_OFS_COUNTER, 8'h00);
        rd_chk("pwm ctrl", ART_OFS_PWM_CTRL, 8'h00);
        check("irq", irq, 1'b0);
        check("oe", pwm_pin_oe, 4'h0);
        rd_chk("unmapped", 6'h28, 8'h00);
        bus(1'b1, ART_OFS_RELOAD, 8'h55, 4'h0, rd);
        rd_chk("reload", ART_OFS_RELOAD, 8'h00);
        $display("test reset done");
    endtask

    task automatic t_force();
        wr(ART_OFS_RELOAD, 8'hFC);
        wr(ART_OFS_CTRL_STATUS, 8'h04);
        rd_chk("forced counter", ART_OFS_COUNTER, 8'hFC);
        rd_chk("ctrl force", ART_OFS_CTRL_STATUS, 8'h00);
        repeat (20) @(posedge clk_sys);
        rd_chk("stopped counter", ART_OFS_COUNTER, 8'hFC);
        // cpu clock, divide by 128: exactly one step falls between the reads
        wr(ART_OFS_CTRL_STATUS, 8'h7C);
        rd_chk("ctrl run force", ART_OFS_CTRL_STATUS, 8'h78);
        rd_chk("cpu before step", ART_OFS_COUNTER, 8'hFC);
        repeat (130) @(posedge clk_sys);
        rd_chk("cpu step", ART_OFS_COUNTER, 8'hFD);
        wr(ART_OFS_CTRL_STATUS, 8'h00);
        $display("test force done");
    endtask

    task automatic t_overflow();
        wr(ART_OFS_COUNTER, 8'hFE);
        wr(ART_OFS_CTRL_STATUS, 8'h8A);
        rd_chk("no cpu ticks", ART_OFS_COUNTER, 8'hFE);
        pulse(1);
        rd_chk("step", ART_OFS_COUNTER, 8'hFF);
        check("irq idle", irq, 1'b0);
        pulse(1);
        rd_chk("reload", ART_OFS_COUNTER, 8'hFC);
        check("irq set", irq, 1'b1);
        rd_chk("flag set", ART_OFS_CTRL_STATUS, 8'h8B);
        rd_chk("flag clear", ART_OFS_CTRL_STATUS, 8'h8A);
        check("irq clear", irq, 1'b0);
        wr(ART_OFS_IRQ_MASK, 8'h01);
        check("irq masked on", irq, 1'b1);
        wr(ART_OFS_IRQ_STATUS, 8'h01);
        check("irq status cleared", irq, 1'b0);
        wr(ART_OFS_IRQ_MASK, 8'h00);
        wr(ART_OFS_CTRL_STATUS, 8'h80);
        pulse(2);
        rd_chk("frozen", ART_OFS_COUNTER, 8'hFC);
        $display("test overflow done");
    endtask

    task automatic t_divider();
        for (int n = 0; n < 8; n++)
        begin
            wr(ART_OFS_CTRL_STATUS, 8'h88 | 8'(n << ART_CC_LSB));
            wr(ART_OFS_COUNTER, 8'h10);
            pulse((1 << n) - 1);
            rd_chk("divider hold", ART_OFS_COUNTER, 8'h10);
            pulse(1);
            rd_chk("divider step", ART_OFS_COUNTER, 8'h11);
        end
        wr(ART_OFS_CTRL_STATUS, 8'h80);
        $display("test divider done");
    endtask

    task automatic t_pwm();
        wr(ART_OFS_PWM_CTRL, 8'h10);
        check("oe ch0", pwm_pin_oe, 4'h1);
        wr(ART_OFS_RELOAD, 8'hF0);
        wr(ART_OFS_DUTY0, 8'hF8);
        // channel 3 keeps its reset duty of zero
        wr(ART_OFS_DUTY0 + 6'h04, 8'hFF);
        wr(ART_OFS_DUTY0 + 6'h08, 8'hF9);
        rd_chk("duty ch1", ART_OFS_DUTY0 + 6'h04, 8'hFF);
        wr(ART_OFS_COUNTER, 8'hFF);
        wr(ART_OFS_CTRL_STATUS, 8'h88);
        check("pin above", pwm_pin, 4'h0);
        pulse(1);
        check("pin at reload", pwm_pin, 4'h1);
        pulse(8);
        check("pin at compare", pwm_pin, 4'h1);
        pulse(1);
        check("pin past compare", pwm_pin, 4'h0);
        wr(ART_OFS_DUTY0, 8'hFF);
        check("shadow held", pwm_pin, 4'h0);
        wr(ART_OFS_CTRL_STATUS, 8'h80);
        wr(ART_OFS_PWM_CTRL, 8'h11);
        check("polarity flip", pwm_pin, 4'h1);
        wr(ART_OFS_PWM_CTRL, 8'hF0);
        check("oe all", pwm_pin_oe, 4'hF);
        check("pins per channel", pwm_pin, 4'h6);
        wr(ART_OFS_PWM_CTRL, 8'h00);
        check("pins off", pwm_pin, 4'h0);
        $display("test pwm done");
    endtask

    // ==========================================================
    // main sequence
    initial
    begin
        repeat (2) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        t_reset();
        t_force();
        t_overflow();
        t_divider();
        t_pwm();
        final_report();
    end
endmodule
